// ### rtl/rof_consts.svh
// timing counts, limits and register map of the resonant on-time and fault core
`ifndef ROF_CONSTS_SVH
`define ROF_CONSTS_SVH
`define ROF_CLK_MHZ             100
`define ROF_TICK_NS             10
`define ROF_FLT_ON_US           2
`define ROF_FLT_OFF_US          20
`define ROF_FLT_ON_CYC          (`ROF_FLT_ON_US * `ROF_CLK_MHZ)
`define ROF_FLT_OFF_CYC         (`ROF_FLT_OFF_US * `ROF_CLK_MHZ)
`define ROF_CS_CLEAR_PULSES     50
`define ROF_CNT_W               16
`define ROF_ADR_CTRL            8'h00
`define ROF_ADR_DEAD            8'h04
`define ROF_ADR_BLANK           8'h08
`define ROF_ADR_FBLIM           8'h0C
`define ROF_ADR_AREC            8'h10
`define ROF_ADR_CSLIM           8'h14
`define ROF_ADR_STAT            8'h18
`define ROF_ADR_ONTIME          8'h1C
`define ROF_CTRL_RST            32'h0000_0000
`define ROF_DEAD_RST            16'h0014
`define ROF_BLANK_RST           16'h001E
`define ROF_FBLIM_RST           32'h000F_4240
`define ROF_AREC_RST            32'h05F5_E100
`define ROF_CSLIM_RST           16'h0008
`define ROF_ONT_INIT            16'h0064
`define ROF_B_EN                0
`define ROF_B_FBCNT             1
`define ROF_B_CUMUL             2
`define ROF_B_LATCH             3
`define ROF_B_SOFT              4
`define ROF_B_SKIP              5
`define ROF_B_UNDERVOLTAGE_LOCKOUT              6
`define ROF_B_SUPRST            7
`endif

// ### rtl/rof_pkg.sv
// types of the resonant on-time and fault core
`default_nettype none
package rof_pkg;
   typedef enum logic [2:0] {ROF_IDLE, ROF_DT_HI, ROF_HIGH, ROF_DT_LO, ROF_LOW,
                             ROF_PROT} rof_phase_t;
   typedef struct packed {
      logic [31:0] timer;
      logic [15:0] pulses;
      logic [15:0] fcnt;
      logic        conf;
      logic        filt;
   } rof_flt_t;
endpackage : rof_pkg
`default_nettype wire

// ### rtl/rof_if.sv
// link between the switching core and its fault filter
`timescale 1ns/1ps
`default_nettype none
interface rof_flt_if;
   logic        fault_raw;
   logic        hs_pulse;
   logic        clear;
   logic        cnt_mode;
   logic        cumulative;
   logic [31:0] limit;
   logic        confirmed;
   logic        filtered;
   modport core (output fault_raw, hs_pulse, clear, cnt_mode, cumulative, limit,
                 input confirmed, filtered);
   modport filt (input fault_raw, hs_pulse, clear, cnt_mode, cumulative, limit,
                 output confirmed, filtered);
endinterface : rof_flt_if
`default_nettype wire

// ### rtl/rof_fb_fault.sv
// feedback-fault noise filter and confirmation timer or pulse counter
`timescale 1ns/1ps
`default_nettype none
`include "rof_consts.svh"
module rof_fb_fault (
   input  wire logic clk_i,
   input  wire logic rst_i,
   rof_flt_if.filt   f
);
   import rof_pkg::*;
   rof_flt_t s;
   rof_flt_t next_s;

   always_comb begin
      next_s = s;
      // asymmetric filter: 2 us to activate, 20 us to release
      if (f.fault_raw != s.filt) begin
         next_s.fcnt = s.fcnt + 16'h0001;
         if (!s.filt && s.fcnt >= 16'(`ROF_FLT_ON_CYC - 1)) begin
            next_s.filt = 1'b1;
            next_s.fcnt = 16'h0000;
         end else if (s.filt && s.fcnt >= 16'(`ROF_FLT_OFF_CYC - 1)) begin
            next_s.filt = 1'b0;
            next_s.fcnt = 16'h0000;
         end
      end else begin
         next_s.fcnt = 16'h0000;
      end
      if (s.filt) begin
         if (!f.cnt_mode) begin
            next_s.timer = s.timer + 32'h0000_0001;
         end else if (f.hs_pulse) begin
            next_s.pulses = s.pulses + 16'h0001;
         end
      end else if (!f.cumulative) begin
         next_s.timer  = 32'h0000_0000;
         next_s.pulses = 16'h0000;
      end // cumulative: hold value
      if (f.clear) begin
         next_s.timer  = 32'h0000_0000;
         next_s.pulses = 16'h0000;
         next_s.conf   = 1'b0;
      end
      // a confirmation in the same cycle as a clear still wins
      if ((!f.cnt_mode && s.timer >= f.limit) ||
          (f.cnt_mode && {16'h0000, s.pulses} >= f.limit)) begin
         next_s.conf = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign f.confirmed = s.conf;
   assign f.filtered  = s.filt;
endmodule : rof_fb_fault
`default_nettype wire

// ### rtl/rof_core.sv
// resonant on-time modulator, dead time, fault supervision and wishbone registers
// How it works
// - after dead time, turn high side on and count on-time up every 10 ns.
// - end high-side conduction when the on-time comparator trips.
// - insert dead time with both switches off before low side turns on.
// - low side counts stored on-time to zero, then off and dead time.
// - if comparator stays active, reuse the last valid on-time.
// - during startup the soft-start reference replaces the feedback reference.
// - filtered feedback fault enables a timer or a pulse counter by option.
// - timer option confirms the fault when the timer reaches its limit.
// - counter option confirms by counting high-side pulses.
// - non-cumulative option clears timer or counter when fault goes away.
// - fault must persist 2 us to activate, be absent 20 us to release.
// - cumulative option holds the accumulated value when the fault ends.
// - skip-mode entry or undervoltage lockout clears the fault timer or counter.
// - confirmed fault stops all drive pulses and enters protection.
// - auto-recovery waits a fixed off-time then restarts via soft start.
// - latched protection holds drivers off until supply reset threshold.
// - each current-sense fault comparator trip increments a fault counter.
// - current-sense counter overflow enters latched or auto-recovery protection.
// - clear the current-sense counter after 50 quiet high-side pulses.
// - ignore the on-time comparator during blanking after high-side turn-on.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rof_consts.svh"
module rof_core #(
   parameter logic [15:0] CS_LIMIT = `ROF_CSLIM_RST
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // classic wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // comparators and supply status
   input  wire logic        ontime_cmp_i,
   input  wire logic        fb_fault_cmp_i,
   input  wire logic        cs_fault_cmp_i,
   input  wire logic        undervoltage_lockout_i,
   input  wire logic        supply_reset_i,
   // drive and status
   output logic             drv_high_o,
   output logic             drv_low_o,
   output logic             soft_start_ref_o,
   output rof_pkg::rof_phase_t phase_o
);
   import rof_pkg::*;

   typedef struct packed {
      rof_phase_t  ph;
      logic [15:0] cnt;
      logic [15:0] ontime;
      logic [15:0] dt;
      logic [15:0] blank;
      logic        trip_hist;
      logic [15:0] cs_cnt;
      logic [7:0]  cs_quiet;
      logic        cs_seen;
      logic        cs_prev;
      logic [31:0] arec;
      logic        latched;
      logic        prot_cs;
      logic [31:0] ctrl;
      logic [15:0] dead;
      logic [15:0] blank_len;
      logic [31:0] fb_lim;
      logic [31:0] arec_len;
      logic [31:0] rdat;
      logic        ack;
      logic [1:0]  sync_ot;
      logic [1:0]  sync_fb;
      logic [1:0]  sync_cs;
      logic [1:0]  sync_uv;
      logic [1:0]  sync_sr;
      logic        skip_prev;
   } rof_state_t;

   rof_state_t s;
   rof_state_t next_s;
   rof_flt_if  flt ();

   rof_fb_fault u_fb_fault (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .f     (flt.filt)
   );

   // byte-lane merge of a write word
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction : wmerge

   logic ot_cmp;
   logic fb_cmp;
   logic cs_cmp;
   logic undervoltage_lockout;
   logic sup_rst;
   logic hs_start;
   logic wb_wr;
   logic skip_rise;
   assign ot_cmp    = s.sync_ot[1];
   assign fb_cmp    = s.sync_fb[1];
   assign cs_cmp    = s.sync_cs[1];
   assign undervoltage_lockout      = s.sync_uv[1] | s.ctrl[`ROF_B_UNDERVOLTAGE_LOCKOUT];
   assign sup_rst   = s.sync_sr[1] | s.ctrl[`ROF_B_SUPRST];
   assign hs_start  = (s.ph == ROF_DT_HI) && (s.dt >= s.dead);
   assign wb_wr     = cyc_i && stb_i && we_i && !s.ack;
   assign skip_rise = s.ctrl[`ROF_B_SKIP] && !s.skip_prev;

   assign flt.fault_raw  = fb_cmp;
   assign flt.hs_pulse   = hs_start;
   // a restart out of protection begins with an empty fault count
   assign flt.clear      = skip_rise || undervoltage_lockout || (s.ph == ROF_PROT);
   assign flt.cnt_mode   = s.ctrl[`ROF_B_FBCNT];
   assign flt.cumulative = s.ctrl[`ROF_B_CUMUL];
   assign flt.limit      = s.fb_lim;

   always_comb begin
      next_s = s;
      next_s.sync_ot   = {s.sync_ot[0], ontime_cmp_i};
      next_s.sync_fb   = {s.sync_fb[0], fb_fault_cmp_i};
      next_s.sync_cs   = {s.sync_cs[0], cs_fault_cmp_i};
      next_s.sync_uv   = {s.sync_uv[0], undervoltage_lockout_i};
      next_s.sync_sr   = {s.sync_sr[0], supply_reset_i};
      next_s.skip_prev = s.ctrl[`ROF_B_SKIP];
      next_s.cs_prev   = cs_cmp;

      // ------------------------------------------------------------
      // switching sequence
      // ------------------------------------------------------------
      unique case (s.ph)
         ROF_IDLE: begin
            if (s.ctrl[`ROF_B_EN]) begin
               next_s.ph = ROF_DT_HI;
               next_s.dt = 16'h0000;
            end
         end
         ROF_DT_HI: begin
            next_s.dt = s.dt + 16'h0001;
            if (hs_start) begin
               next_s.ph    = ROF_HIGH;
               next_s.cnt   = 16'h0000;
               next_s.blank = 16'h0000;
            end
         end
         ROF_HIGH: begin
            next_s.cnt = s.cnt + 16'h0001;
            if (s.blank < s.blank_len) begin
               next_s.blank = s.blank + 16'h0001;
               if (s.blank == 16'h0000) begin
                  next_s.trip_hist = ot_cmp; // comparator already high at turn-on
               end
            end else if (s.trip_hist) begin
               // comparator never released: replay last on-time
               if (!ot_cmp) begin
                  next_s.trip_hist = 1'b0;
               end
               if (s.cnt + 16'h0001 >= s.ontime) begin
                  next_s.ph = ROF_DT_LO;
                  next_s.dt = 16'h0000;
               end
            end else if (ot_cmp || s.cnt == 16'hFFFE) begin
               // cap keeps the stored on-time from wrapping to zero
               next_s.ontime = s.cnt + 16'h0001;
               next_s.ph     = ROF_DT_LO;
               next_s.dt     = 16'h0000;
            end
         end
         ROF_DT_LO: begin
            next_s.dt = s.dt + 16'h0001;
            if (s.dt >= s.dead) begin
               next_s.ph  = ROF_LOW;
               next_s.cnt = s.ontime;
            end
         end
         ROF_LOW: begin
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt <= 16'h0001) begin
               next_s.ph = ROF_DT_HI;
               next_s.dt = 16'h0000;
            end
         end
         ROF_PROT: begin
            if (s.latched) begin
               if (sup_rst) begin
                  next_s.latched = 1'b0;
                  next_s.ph      = ROF_IDLE;
               end
            end else if (s.arec >= s.arec_len) begin
               next_s.ph     = ROF_IDLE;
               next_s.ctrl[`ROF_B_SOFT] = 1'b1;
               next_s.ontime = `ROF_ONT_INIT;
            end else begin
               next_s.arec = s.arec + 32'h0000_0001;
            end
         end
      endcase
      if (!s.ctrl[`ROF_B_EN] && s.ph != ROF_PROT) begin
         next_s.ph = ROF_IDLE;
      end

      // ------------------------------------------------------------
      // current-sense short-circuit counter
      // ------------------------------------------------------------
      if (cs_cmp && !s.cs_prev) begin
         next_s.cs_cnt  = s.cs_cnt + 16'h0001;
         next_s.cs_seen = 1'b1;
      end
      if (hs_start) begin
         if (s.cs_seen || cs_cmp) begin
            next_s.cs_quiet = 8'h00;
            next_s.cs_seen  = 1'b0;
         end else if (s.cs_quiet >= 8'(`ROF_CS_CLEAR_PULSES - 1)) begin
            next_s.cs_cnt   = 16'h0000;
            next_s.cs_quiet = 8'h00;
         end else begin
            next_s.cs_quiet = s.cs_quiet + 8'h01;
         end
      end

      // ------------------------------------------------------------
      // protection entry
      // ------------------------------------------------------------
      if (s.ph != ROF_PROT && (flt.confirmed || s.cs_cnt >= CS_LIMIT)) begin
         next_s.ph      = ROF_PROT;
         next_s.arec    = 32'h0000_0000;
         next_s.latched = s.ctrl[`ROF_B_LATCH];
         next_s.prot_cs = s.cs_cnt >= CS_LIMIT;
         next_s.cs_cnt  = 16'h0000;
      end
      if (undervoltage_lockout) begin
         next_s.cs_cnt = 16'h0000;
      end

      // ------------------------------------------------------------
      // wishbone slave, one wait state
      // ------------------------------------------------------------
      next_s.ack = cyc_i && stb_i && !s.ack;
      if (wb_wr) begin
         unique case (adr_i[7:0])
            `ROF_ADR_CTRL:          next_s.ctrl      = wmerge(s.ctrl, dat_i, sel_i);
            `ROF_ADR_DEAD:          next_s.dead      = 16'(wmerge({16'h0000, s.dead}, dat_i,
                                                                  sel_i));
            `ROF_ADR_BLANK:         next_s.blank_len = 16'(wmerge({16'h0000, s.blank_len},
                                                                  dat_i, sel_i));
            `ROF_ADR_FBLIM:         next_s.fb_lim    = wmerge(s.fb_lim, dat_i, sel_i);
            `ROF_ADR_AREC:          next_s.arec_len  = wmerge(s.arec_len, dat_i, sel_i);
            default: ;
         endcase
      end
      unique case (adr_i[7:0])
         `ROF_ADR_CTRL:          next_s.rdat = s.ctrl;
         `ROF_ADR_DEAD:          next_s.rdat = {16'h0000, s.dead};
         `ROF_ADR_BLANK:         next_s.rdat = {16'h0000, s.blank_len};
         `ROF_ADR_FBLIM:         next_s.rdat = s.fb_lim;
         `ROF_ADR_AREC:          next_s.rdat = s.arec_len;
         `ROF_ADR_CSLIM:         next_s.rdat = {16'h0000, CS_LIMIT};
         `ROF_ADR_STAT:          next_s.rdat = {8'h00, s.cs_quiet, s.cs_cnt[7:0], 1'b0,
                                                s.ph, s.prot_cs, s.latched,
                                                flt.confirmed, flt.filtered};
         `ROF_ADR_ONTIME:        next_s.rdat = {16'h0000, s.ontime};
         default:                next_s.rdat = 32'h0000_0000;
      endcase
      // soft start ends once a full cycle has completed after restart
      if (s.ph == ROF_LOW && s.cnt <= 16'h0001 && !(wb_wr &&
          adr_i == `ROF_ADR_CTRL)) begin
         next_s.ctrl[`ROF_B_SOFT] = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s           <= '0;
         s.ph        <= ROF_IDLE;
         s.ctrl      <= `ROF_CTRL_RST;
         s.dead      <= `ROF_DEAD_RST;
         s.blank_len <= `ROF_BLANK_RST;
         s.fb_lim    <= `ROF_FBLIM_RST;
         s.arec_len  <= `ROF_AREC_RST;
         s.ontime    <= `ROF_ONT_INIT;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign drv_high_o       = (s.ph == ROF_HIGH);
   assign drv_low_o        = (s.ph == ROF_LOW);
   assign soft_start_ref_o = s.ctrl[`ROF_B_SOFT];
   assign phase_o          = s.ph;
   assign dat_o            = s.rdat;
   assign ack_o            = s.ack;
endmodule : rof_core
`default_nettype wire

// ### tb/rof_core_props.sv
// assertion checker for the resonant on-time and fault core
`timescale 1ns/1ps
`default_nettype none
module rof_core_props
   import rof_pkg::*;
#(
   parameter logic [15:0] CS_LIMIT = 16'h0008
) (
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                cyc_i,
   input wire logic                stb_i,
   input wire logic                ack_o,
   input wire logic                drv_high_o,
   input wire logic                drv_low_o,
   input wire rof_pkg::rof_phase_t phase_o
);
   logic [15:0] hi_len;
   logic [15:0] lo_len;
   // ----------------------------------------
   // lengths of the latest gate pulses
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_len <= 16'h0;
         lo_len <= 16'h0;
      end else begin
         if ($rose(drv_high_o)) hi_len <= 16'h1;
         else if (drv_high_o) hi_len <= hi_len + 16'h1;
         if ($rose(drv_low_o)) lo_len <= 16'h1;
         else if (drv_low_o) lo_len <= lo_len + 16'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_no_overlap; !(drv_high_o && drv_low_o); endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
   property p_dead_gap; $fell(drv_high_o) |-> !drv_low_o [*3]; endproperty
   a_dead_gap: assert property (p_dead_gap) else $error("no dead time after high");
   property p_low_from_dead; $rose(drv_low_o) |-> $past(phase_o) == ROF_DT_LO; endproperty
   a_low_from_dead: assert property (p_low_from_dead) else $error("low without dead");
   property p_high_from_dead; $rose(drv_high_o) |-> $past(phase_o) == ROF_DT_HI; endproperty
   a_high_from_dead: assert property (p_high_from_dead) else $error("high without dead");
   property p_blank; $rose(drv_high_o) |-> (drv_high_o || phase_o == ROF_PROT) [*8]; endproperty
   a_blank: assert property (p_blank) else $error("high pulse cut in blanking");
   property p_symmetric;
      $fell(drv_low_o) && phase_o == ROF_DT_HI |-> lo_len == hi_len;
   endproperty
   a_symmetric: assert property (p_symmetric) else $error("low length differs");
   property p_prot_quiet; phase_o == ROF_PROT |-> !drv_high_o && !drv_low_o; endproperty
   a_prot_quiet: assert property (p_prot_quiet) else $error("drive in protection");
   property p_ack_once; ack_o |=> !ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
endmodule : rof_core_props
bind rof_core rof_core_props #(.CS_LIMIT(CS_LIMIT)) u_rof_core_props (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .drv_high_o(drv_high_o),
   .drv_low_o(drv_low_o), .phase_o(phase_o));
`default_nettype wire

// ### tb/rof_stage.sv
// power stage model: on-time comparator and current-sense fault comparator
`timescale 1ns/1ps
`default_nettype none
module rof_stage (
   input  wire logic clk_i,
   input  wire logic drv_high_i,
   output var logic  ontime_cmp_o,
   output var logic  cs_fault_cmp_o
);
   int unsigned on_cyc  = 50;
   int unsigned cnt     = 0;
   int unsigned cs_left = 0;
   bit          stuck   = 1'b0;
   initial begin
      ontime_cmp_o = 1'b0;
      cs_fault_cmp_o = 1'b0;
   end
   // ramp crosses the set point after on_cyc, with a switching spike early in the pulse
   always @(posedge clk_i) begin
      cnt <= drv_high_i ? cnt + 1 : 0;
      ontime_cmp_o <= stuck || (drv_high_i && (cnt == 3 || cnt >= on_cyc));
      cs_fault_cmp_o <= drv_high_i && cnt == 10 && cs_left != 0;
      if (drv_high_i && cnt == 10 && cs_left != 0) cs_left <= cs_left - 1;
   end
endmodule : rof_stage
`default_nettype wire

// ### tb/rof_core_test.sv
// self-checking bench for the resonant on-time and fault core
`timescale 1ns/1ps
`default_nettype none
module rof_core_test;
   import rof_pkg::*;
   typedef struct {logic [31:0] m; logic [31:0] e;} rof_note_t;
   localparam logic [15:0] CS_LIM = 16'h0008;
   localparam logic [31:0] AREC = 32'd4000;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic        fb_fault_cmp_i = 1'b0, undervoltage_lockout_i = 1'b0, supply_reset_i = 1'b0;
   logic        ack_o, drv_high_o, drv_low_o, soft_start_ref_o, ontime_cmp_i, cs_fault_cmp_i;
   logic        hi_q = 1'b0;
   rof_phase_t  phase_o;
   rof_note_t   notes[$];
   rof_note_t   nt;
   int          error_cnt = 0, cmp_count = 0, hcnt = 0, hl = 0, rises = 0, n, d, r0;
   logic [7:0]  radr[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20};
   logic [31:0] rval[8] = '{32'h0, 32'h14, 32'h1E, 32'h000F_4240, 32'h05F5_E100,
                            {16'h0, CS_LIM}, 32'h64, 32'h0};
   always #5 clk_i = ~clk_i;
   rof_core #(.CS_LIMIT(CS_LIM)) u_rof_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .ontime_cmp_i(ontime_cmp_i), .fb_fault_cmp_i(fb_fault_cmp_i),
      .cs_fault_cmp_i(cs_fault_cmp_i), .undervoltage_lockout_i(undervoltage_lockout_i),
      .supply_reset_i(supply_reset_i), .drv_high_o(drv_high_o), .drv_low_o(drv_low_o),
      .soft_start_ref_o(soft_start_ref_o), .phase_o(phase_o));
   rof_stage u_rof_stage (.clk_i(clk_i), .drv_high_i(drv_high_o),
      .ontime_cmp_o(ontime_cmp_i), .cs_fault_cmp_o(cs_fault_cmp_i));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask : tick
   // one classic cycle; a read leaves its expected value and mask as a note
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] v, m);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= v;
      if (!w) notes.push_back('{m, v});
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (!ack_o && k < 20);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (ack_o !== 1'b1) begin
         error_cnt++;
         summarize();
      end
   endtask : wb
   task automatic wait_rises(input int c);
      int r;
      r = rises + c;
      n = 0;
      while (rises < r && n < 40000) begin
         @(posedge clk_i);
         n++;
      end
      if (rises < r) begin
         error_cnt++;
         summarize();
      end
   endtask : wait_rises
   task automatic wait_prot(input logic want, input int lim);
      n = 0;
      while ((phase_o == ROF_PROT) != want && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if ((phase_o == ROF_PROT) != want) begin
         error_cnt++;
         summarize();
      end
   endtask : wait_prot
   task automatic setup(input logic [31:0] ctrl, input logic [31:0] lim);
      rst_i <= 1'b1;
      tick(12);
      rst_i <= 1'b0;
      wb(8'h04, 1'b1, 32'h4, 32'h0);
      wb(8'h0C, 1'b1, lim, 32'h0);
      wb(8'h10, 1'b1, AREC, 32'h0);
      wb(8'h00, 1'b1, ctrl, 32'h0);
   endtask : setup
   // measures high pulses and compares read data against the oldest note
   always @(posedge clk_i) begin
      hi_q <= drv_high_o;
      if (drv_high_o) hcnt <= hcnt + 1;
      else if (hi_q) begin
         hl <= hcnt;
         hcnt <= 0;
      end
      if (drv_high_o && !hi_q) rises <= rises + 1;
      if (ack_o && !we_i) begin
         nt = notes.pop_front();
         check(dat_o & nt.m, nt.e);
      end
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      void'($urandom(95782));
      tick(12);
      rst_i <= 1'b0;
      wb(8'h20, 1'b1, 32'h5A5A_5A5A, 32'h0);
      wb(8'h14, 1'b1, 32'h0000_00FF, 32'h0);
      foreach (radr[i]) wb(radr[i], 1'b0, rval[i], 32'hFFFF_FFFF);
      $display("test registers done");
      d = 40 + $urandom % 40;
      u_rof_stage.on_cyc = d;
      setup(32'h1, 32'h00FF_FFFF);
      wait_rises(3);
      check(32'(hl >= d && hl <= d + 6), 1);
      n = 0;
      while (drv_low_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (drv_low_o !== 1'b1) begin
         error_cnt++;
         summarize();
      end
      u_rof_stage.stuck = 1'b1;
      wait_rises(3);
      check(32'(hl >= d && hl <= d + 6), 1);
      u_rof_stage.stuck = 1'b0;
      $display("test switching done");
      setup(32'h1, 32'd3000);
      fb_fault_cmp_i <= 1'b1;
      tick(150);
      fb_fault_cmp_i <= 1'b0;
      tick(10);
      wb(8'h18, 1'b0, 32'h0, 32'h1);
      fb_fault_cmp_i <= 1'b1;
      tick(240);
      wb(8'h18, 1'b0, 32'h1, 32'h1);
      tick(2880);
      check(32'(phase_o == ROF_PROT), 0);
      wait_prot(1'b1, 150);
      fb_fault_cmp_i <= 1'b0;
      wait_prot(1'b0, 4200);
      check(32'(n >= 3990 && n <= 4010), 1);
      tick(2);
      check({31'h0, soft_start_ref_o}, 1);
      tick(20);
      check(32'(phase_o == ROF_PROT), 0);
      $display("test fault timer done");
      for (int k = 0; k < 4; k++) begin
         setup(k != 0 ? 32'h5 : 32'h1, 32'd3000);
         fb_fault_cmp_i <= 1'b1;
         tick(500);
         fb_fault_cmp_i <= 1'b0;
         tick(2300);
         if (k == 2) wb(8'h00, 1'b1, 32'h25, 32'h0);
         if (k == 2) wb(8'h00, 1'b1, 32'h5, 32'h0);
         if (k == 3) undervoltage_lockout_i <= 1'b1;
         tick(5);
         undervoltage_lockout_i <= 1'b0;
         fb_fault_cmp_i <= 1'b1;
         tick(500);
         fb_fault_cmp_i <= 1'b0;
         tick(2400);
         check(32'(phase_o == ROF_PROT), 32'(k == 1));
      end
      $display("test cumulative done");
      setup(32'h3, 32'd10);
      r0 = rises;
      fb_fault_cmp_i <= 1'b1;
      wait_prot(1'b1, 8000);
      check(32'(rises - r0 >= 10 && rises - r0 <= 14), 1);
      fb_fault_cmp_i <= 1'b0;
      $display("test pulse counter done");
      setup(32'h9, 32'h00FF_FFFF);
      u_rof_stage.cs_left = 5;
      wait_rises(8);
      wb(8'h18, 1'b0, 32'h0500, 32'hFF00);
      wait_rises(52);
      wb(8'h18, 1'b0, 32'h0, 32'hFF00);
      u_rof_stage.cs_left = CS_LIM + 1;
      wait_prot(1'b1, 4000);
      wb(8'h18, 1'b0, 32'hC, 32'hC);
      tick(5000);
      check(32'(phase_o == ROF_PROT), 1);
      supply_reset_i <= 1'b1;
      tick(5);
      supply_reset_i <= 1'b0;
      tick(10);
      check(32'(phase_o == ROF_PROT), 0);
      $display("test short circuit done");
      summarize();
   end
endmodule : rof_core_test
`default_nettype wire
